// ==== design/erd_pkg.sv ====
// Functional notes
// RULE1 - Stay off the bus unless A19..A16 match the programmed segment; the code compares only A19..A17 and lets A16 pick the map half.
// RULE2 - On a segment match, respond only if the low 16 bits hit an enabled block.
// RULE3 - One enable per 2K block; enables land in the last programmed segment.
// RULE4 - A single-address enable sets only the 2K block holding that address.
// RULE5 - A plain enable replaces all enables; an additive one keeps earlier ones.
// RULE6 - Two neighbouring segments differing in A16 may both be emulated.
// RULE7 - The 128K window folds onto 32K of RAM modulo 32K.
// RULE8 - The segment value resets to hex F.
// RULE9 - Debugger on and analyzer start writes debug info into the reserved area.
// RULE10 - If the reserved area is not emulated, analyzer start with the debugger on reports failure.
// RULE11 - Clear-all disables every block so the device never answers the bus.
// RULE12 - The target address is 20 bits wide.
// RULE13 - Target writes never alter the emulation RAM.
// RULE14 - Data is driven only on read cycles that hit an enabled block.
package erd_pkg;
   localparam int        TADDR_W   = 20;
   localparam int        LOW_W     = 16;
   localparam int        SEG_W     = 4;
   localparam int        REGION_W  = 3;
   localparam int        RAM_AW    = 15;
   localparam int        DATA_W    = 8;
   localparam int        BLK_LSB   = 11;
   localparam int        BLK_W     = 5;
   localparam int        MAP_BITS  = 64;
   localparam int        SEG_LSB   = 16;
   localparam int        HALF_BIT  = 16;
   localparam int        READ_LAT  = 2;
   localparam logic [SEG_W-1:0]    SEG_RESET = 4'hf;
   localparam logic [MAP_BITS-1:0] MAP_RESET = 64'h0;

   // Map index: A16 picks the half, A15..A11 the 2K block
   function automatic logic [5:0] erd_blk_idx(input logic half, input logic [LOW_W-1:0] a);
      erd_blk_idx = {half, a[LOW_W-1:BLK_LSB]};
   endfunction

   // Blocks lo..hi inclusive within one 64K half
   function automatic logic [MAP_BITS-1:0] erd_range_mask(input logic half,
                                                          input logic [BLK_W-1:0] lo,
                                                          input logic [BLK_W-1:0] hi);
      logic [MAP_BITS-1:0] m;
      m = '0;
      for (int i = 0; i < 32; i++) begin
         if (5'(i) >= lo && 5'(i) <= hi) begin
            m[{half, 5'(i)}] = 1'b1;
         end
      end
      erd_range_mask = m;
   endfunction
endpackage

// ==== design/erd_ram.sv ====
`timescale 1ns/1ps
module erd_ram
   import erd_pkg::*;
#(
   parameter int AW = RAM_AW,
   parameter int DW = DATA_W
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // erd_ram

// ==== design/erd_decoder.sv ====
`timescale 1ns/1ps
module erd_decoder
   import erd_pkg::*;
#(
   parameter logic [LOW_W-1:0] RSV_ADDR = 16'h0000
) (
   input  wire logic                 SYS_CLK,
   input  wire logic                 SYS_RST,
   input  wire logic [TADDR_W-1:0]   T_ADDR,
   input  wire logic                 T_RD,
   input  wire logic                 T_WR,
   output logic      [DATA_W-1:0]    T_DATA_O,
   output logic                      T_DATA_OE,
   input  wire logic                 SEG_WR,
   input  wire logic [SEG_W-1:0]     SEGMENT_SELECT_VALUE,
   input  wire logic                 BLOCK_ENABLE_REQUEST,
   input  wire logic [LOW_W-1:0]     ENABLE_START,
   input  wire logic [LOW_W-1:0]     ENABLE_END,
   input  wire logic                 ENABLE_RANGE,
   input  wire logic                 ENABLE_ADD,
   input  wire logic                 CLEAR_ALL_ENABLES,
   input  wire logic                 HOST_WR,
   input  wire logic [RAM_AW-1:0]    HOST_ADDR,
   input  wire logic [DATA_W-1:0]    HOST_WDATA,
   input  wire logic                 DEBUGGER_ENABLE,
   input  wire logic                 ANALYZER_START,
   input  wire logic [DATA_W-1:0]    DEBUG_INFO,
   output logic                      DEBUG_OK,
   output logic                      DEBUG_FAIL,
   output logic      [MAP_BITS-1:0]  ENABLE_STATUS_REPORT,
   output logic      [SEG_W-1:0]     CUR_SEGMENT
);

   ////////////////////////////////////////////////////////////////////////////////
   // Enable map and segment
   logic [SEG_W-1:0]    segment;
   logic [MAP_BITS-1:0] enable_map;
   logic [SEG_W-1:0]    next_segment;
   logic [MAP_BITS-1:0] next_enable_map;
   logic [MAP_BITS-1:0] req_mask;
   logic [BLK_W-1:0]    req_lo;
   logic [BLK_W-1:0]    req_hi;

   always_comb begin
      next_segment    = segment;
      next_enable_map = enable_map;
      req_lo          = ENABLE_START[LOW_W-1:BLK_LSB];
      req_hi          = ENABLE_RANGE ? ENABLE_END[LOW_W-1:BLK_LSB] : req_lo; // RULE4
      req_mask        = erd_range_mask(segment[0], req_lo, req_hi); // RULE3
      if (CLEAR_ALL_ENABLES) begin
         next_enable_map = '0; // RULE11
      end else if (BLOCK_ENABLE_REQUEST) begin
         if (ENABLE_ADD) begin
            next_enable_map = enable_map | req_mask; // RULE5
         end else begin
            next_enable_map = req_mask; // RULE5
         end
      end else if (SEG_WR) begin
         next_segment = SEGMENT_SELECT_VALUE; // RULE3
         // Leaving the 128K region makes every old enable meaningless
         if (SEGMENT_SELECT_VALUE[SEG_W-1:1] != segment[SEG_W-1:1]) begin
            next_enable_map = '0; // RULE6
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         segment    <= SEG_RESET; // RULE8
         enable_map <= MAP_RESET;
      end else begin
         segment    <= next_segment;
         enable_map <= next_enable_map;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   logic region_match;
   logic blk_hit;
   logic rd_hit;

   always_comb begin
      // Upper three bits must match; A16 then selects the half of the map
      region_match = (T_ADDR[TADDR_W-1:SEG_LSB+1] == segment[SEG_W-1:1]); // RULE1 RULE6 RULE12
      blk_hit      = enable_map[erd_blk_idx(T_ADDR[HALF_BIT], T_ADDR[LOW_W-1:0])]; // RULE2
      rd_hit       = T_RD && !T_WR && region_match && blk_hit; // RULE14
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Debugger reserved area
   logic rsv_hit;
   logic dbg_wr;
   logic next_dbg_ok;
   logic next_dbg_fail;

   always_comb begin
      rsv_hit       = enable_map[erd_blk_idx(segment[0], RSV_ADDR)];
      dbg_wr        = ANALYZER_START && DEBUGGER_ENABLE && rsv_hit; // RULE9
      next_dbg_ok   = dbg_wr;
      next_dbg_fail = ANALYZER_START && DEBUGGER_ENABLE && !rsv_hit; // RULE10
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Emulation RAM; only host loads and the debugger write it
   logic              ram_we;
   logic [RAM_AW-1:0] ram_waddr;
   logic [DATA_W-1:0] ram_wdata;
   logic [RAM_AW-1:0] ram_raddr;
   logic [DATA_W-1:0] ram_rdata;

   always_comb begin
      ram_we    = dbg_wr || HOST_WR; // RULE13
      ram_waddr = dbg_wr ? RSV_ADDR[RAM_AW-1:0] : HOST_ADDR; // RULE7
      ram_wdata = dbg_wr ? DEBUG_INFO : HOST_WDATA;
      ram_raddr = T_ADDR[RAM_AW-1:0]; // RULE7
   end

   erd_ram #(
      .AW (RAM_AW),
      .DW (DATA_W)
   ) u_ram (
      .clk   (SYS_CLK),
      .we    (ram_we),
      .waddr (ram_waddr),
      .wdata (ram_wdata),
      .raddr (ram_raddr),
      .rdata (ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus drive pipeline
   logic              hit_d1;
   logic              next_hit_d1;
   logic [DATA_W-1:0] next_data;
   logic              next_oe;

   always_comb begin
      next_hit_d1 = rd_hit;
      next_oe     = hit_d1; // RULE14
      next_data   = hit_d1 ? ram_rdata : '0;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         hit_d1    <= 1'b0;
         T_DATA_OE <= 1'b0;
         T_DATA_O  <= '0;
      end else begin
         hit_d1    <= next_hit_d1;
         T_DATA_OE <= next_oe;
         T_DATA_O  <= next_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status outputs
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ENABLE_STATUS_REPORT <= MAP_RESET;
         CUR_SEGMENT          <= SEG_RESET;
         DEBUG_OK             <= 1'b0;
         DEBUG_FAIL           <= 1'b0;
      end else begin
         ENABLE_STATUS_REPORT <= next_enable_map;
         CUR_SEGMENT          <= next_segment;
         DEBUG_OK             <= next_dbg_ok;
         DEBUG_FAIL           <= next_dbg_fail;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_SEG_MISS: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE1
      T_RD && (T_ADDR[TADDR_W-1:SEG_LSB+1] != segment[SEG_W-1:1]) |-> ##2 !T_DATA_OE)
      else $error("Drove bus on segment mismatch");

   AST_BLK_HIT: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE2
      T_RD && !T_WR && region_match && blk_hit |-> ##2 T_DATA_OE)
      else $error("Enabled block read not answered");

   AST_BLK_MISS: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE2
      T_RD && !blk_hit |-> ##2 !T_DATA_OE)
      else $error("Disabled block answered");

   AST_SEG_RESET: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE8
      $past(SYS_RST) |-> (segment == 4'hf) && (CUR_SEGMENT == 4'hf))
      else $error("Segment not F after reset");

   AST_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE11
      CLEAR_ALL_ENABLES |=> (enable_map == '0) ##2 (T_DATA_OE == 1'b0))
      else $error("Clear-all left blocks enabled");

   AST_SEG_LOAD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE3
      SEG_WR && !BLOCK_ENABLE_REQUEST && !CLEAR_ALL_ENABLES
      |=> (segment == $past(SEGMENT_SELECT_VALUE)) ##1 (CUR_SEGMENT == $past(segment)))
      else $error("Segment value not loaded");

   AST_SINGLE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE4
      BLOCK_ENABLE_REQUEST && !ENABLE_RANGE && !ENABLE_ADD && !CLEAR_ALL_ENABLES
      |=> enable_map == (64'h1 << $past(erd_blk_idx(segment[0], ENABLE_START))))
      else $error("Single enable set wrong block");

   AST_ADD_KEEP: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE5
      BLOCK_ENABLE_REQUEST && ENABLE_ADD && !CLEAR_ALL_ENABLES
      |=> (enable_map & $past(enable_map)) == $past(enable_map))
      else $error("Additive enable lost old blocks");

   AST_NO_TWRITE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE13
      ram_we |-> HOST_WR || (ANALYZER_START && DEBUGGER_ENABLE))
      else $error("RAM written by target cycle");

   AST_DBG_WRITE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE9
      ANALYZER_START && DEBUGGER_ENABLE && rsv_hit
      |-> ram_we && (ram_waddr == RSV_ADDR[RAM_AW-1:0]) ##1 DEBUG_OK && !DEBUG_FAIL)
      else $error("Debug info not written");

   AST_DBG_FAIL: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE10
      ANALYZER_START && DEBUGGER_ENABLE && !rsv_hit |=> DEBUG_FAIL && !DEBUG_OK)
      else $error("Missing debug failure report");

   AST_OE_READ: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE14
      T_DATA_OE |-> $past(T_RD, 2) && !$past(T_WR, 2))
      else $error("Bus driven outside a read");

   AST_FOLD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE7
      T_DATA_OE && !$past(ram_we, 2) |-> T_DATA_O == $past(ram_rdata))
      else $error("Read data not from folded RAM");

endmodule // erd_decoder

// ==== sim/erd_cpu_model.sv ====
`timescale 1ns/1ps
module erd_cpu_model
   import erd_pkg::*;
(
   input  wire logic               clk,
   output logic      [TADDR_W-1:0] t_addr,
   output logic                    t_rd,
   output logic                    t_wr,
   input  wire logic [DATA_W-1:0]  t_data,
   input  wire logic               t_oe
);
   initial begin
      t_addr = '0;
      t_rd   = 1'b0;
      t_wr   = 1'b0;
   end
   // Bus cycle held up to the answer edge
   task automatic cycle(input logic [TADDR_W-1:0] a, input logic wr,
                        output logic oe, output logic [DATA_W-1:0] d);
      @(negedge clk);
      t_addr = a;
      t_rd   = ~wr;
      t_wr   = wr;
      repeat (3) @(negedge clk);
      oe     = t_oe;
      d      = t_data;
      t_rd   = 1'b0;
      t_wr   = 1'b0;
      t_addr = ~a;  // Released lines do not keep the last value
   endtask
endmodule // erd_cpu_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import erd_pkg::*;
   logic                clk, rst, t_rd, t_wr, seg_wr, en_req, en_rng, en_add, clr;
   logic                host_wr, dbg_en, an_start, oe, dbg_ok, dbg_fail, ok, fl;
   logic [TADDR_W-1:0]  t_addr;
   logic [DATA_W-1:0]   t_data, host_wdata, dbg_info;
   logic [SEG_W-1:0]    seg_val, cur_seg;
   logic [LOW_W-1:0]    en_start, en_end;
   logic [RAM_AW-1:0]   host_addr;
   logic [MAP_BITS-1:0] status;
   int                  n_fail, compares;

   erd_cpu_model u_cpu (.clk(clk), .t_addr(t_addr), .t_rd(t_rd), .t_wr(t_wr),
                        .t_data(t_data), .t_oe(oe));
   erd_decoder u_dut (.SYS_CLK(clk), .SYS_RST(rst), .T_ADDR(t_addr), .T_RD(t_rd),
      .T_WR(t_wr), .T_DATA_O(t_data), .T_DATA_OE(oe), .SEG_WR(seg_wr),
      .SEGMENT_SELECT_VALUE(seg_val), .BLOCK_ENABLE_REQUEST(en_req),
      .ENABLE_START(en_start), .ENABLE_END(en_end), .ENABLE_RANGE(en_rng),
      .ENABLE_ADD(en_add), .CLEAR_ALL_ENABLES(clr), .HOST_WR(host_wr),
      .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata), .DEBUGGER_ENABLE(dbg_en),
      .ANALYZER_START(an_start), .DEBUG_INFO(dbg_info), .DEBUG_OK(dbg_ok),
      .DEBUG_FAIL(dbg_fail), .ENABLE_STATUS_REPORT(status), .CUR_SEGMENT(cur_seg));

   always #4 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask
   task automatic enable(input logic [15:0] lo, hi, input logic rng, add);
      en_start = lo;
      en_end   = hi;
      en_rng   = rng;
      en_add   = add;
      pulse(en_req);
   endtask
   task automatic fetch(input logic [19:0] a, input logic wr, e_oe, input logic [7:0] e_d);
      logic       o;
      logic [7:0] d;
      u_cpu.cycle(a, wr, o, d);
      check(o, e_oe);
      check(d, e_d);
   endtask
   task automatic start_analyzer();
      int i;
      @(negedge clk);
      an_start = 1'b1;
      @(negedge clk);
      an_start = 1'b0;
      // Report pulse stands for one cycle only
      ok = dbg_ok;
      fl = dbg_fail;
      for (i = 0; i < 4 && ok !== 1'b1 && fl !== 1'b1; i++) begin
         @(negedge clk);
         ok = dbg_ok;
         fl = dbg_fail;
      end
      if (i == 4) begin
         n_fail++;
         give_verdict();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(cur_seg, 4'hf);
      check(status, 64'h0);
      check(oe, 1'b0);
   endtask
   task automatic t_range();
      enable(16'h0000, 16'h17ff, 1'b1, 1'b0);
      check(status, 64'h7 << 32);
      fetch(20'hf0000, 1'b0, 1'b1, 8'ha5);
      fetch(20'hf1800, 1'b0, 1'b0, 8'h00);
      fetch(20'h70000, 1'b0, 1'b0, 8'h00);
      fetch(20'he0000, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic t_fold();
      enable(16'h8000, 16'h87ff, 1'b1, 1'b1);
      check(status, (64'h1 << 48) | (64'h7 << 32));
      fetch(20'hf8000, 1'b0, 1'b1, 8'ha5);
   endtask
   task automatic t_single();
      enable(16'h1000, 16'h0000, 1'b0, 1'b0);
      check(status, 64'h1 << 34);
      fetch(20'hf1000, 1'b0, 1'b1, 8'h3c);
      fetch(20'hf0000, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic t_two_seg();
      seg_val = 4'he;
      pulse(seg_wr);
      check(cur_seg, 4'he);
      enable(16'h0000, 16'h07ff, 1'b1, 1'b1);
      check(status, (64'h1 << 34) | 64'h1);
      fetch(20'he0000, 1'b0, 1'b1, 8'ha5);
      fetch(20'hf1000, 1'b0, 1'b1, 8'h3c);
      fetch(20'he0000, 1'b1, 1'b0, 8'h00);
      fetch(20'he0000, 1'b0, 1'b1, 8'ha5);
   endtask
   task automatic t_debug();
      dbg_en   = 1'b1;
      dbg_info = 8'h77;
      start_analyzer();
      check({ok, fl}, 2'b10);
      fetch(20'he0000, 1'b0, 1'b1, 8'h77);
      pulse(clr);
      check(status, 64'h0);
      fetch(20'he0000, 1'b0, 1'b0, 8'h00);
      start_analyzer();
      check({ok, fl}, 2'b01);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, seg_wr, en_req, en_rng, en_add, clr, host_wr} = '0;
      {dbg_en, an_start, seg_val, en_start, en_end, host_addr} = '0;
      {host_wdata, dbg_info, n_fail, compares} = '0;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      host_wdata = 8'ha5;
      pulse(host_wr);
      host_addr  = 15'h1000;
      host_wdata = 8'h3c;
      pulse(host_wr);
      t_range();
      t_fold();
      t_single();
      t_two_seg();
      t_debug();
      give_verdict();
   end
endmodule // testbench
